// ### hdl/pag_cfg.svh
/*
  Constants of the port A pin block: register byte offsets, reset
  values and widths. Assumes a 32-bit classic Wishbone register bus.
*/
`ifndef PAG_CFG_SVH
`define PAG_CFG_SVH

`define PAG_NUM_PINS   8
`define PAG_ADR_W      8
`define PAG_CH_W       5
`define PAG_ADR_LATCH  8'h00
`define PAG_ADR_DIR    8'h04
`define PAG_ADR_LED    8'h08
`define PAG_ADR_ROUTE  8'h0c
`define PAG_DIR_RST    8'h00
`define PAG_LED_RST    8'h00

`endif

// ### hdl/pag_pkg.sv
/*
  Types of the port A pin block: state records and the pad group.
  Assumes pag_cfg.svh is on the include path.
*/
`include "pag_cfg.svh"

package pag_pkg;

  // drive state of the eight pads
  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe_n;
    logic [7:0] led;
    logic [7:0] analog;
  } pag_pad_t;

  typedef struct packed {
    logic [7:0] s1;
    logic [7:0] s2;
    logic [7:0] s3;
    logic [7:0] q;
  } pag_sync_t;

  typedef struct packed {
    logic [7:0]  dir;
    logic [7:0]  latch;
    logic [7:0]  led;
    logic        ack;
    logic [31:0] rdat;
    pag_pad_t    pad;
  } pag_state_t;

endpackage : pag_pkg

// ### hdl/pag_sync.sv
/*
  Four-flop synchroniser for the eight pad inputs: three shift stages and a filtered output stage.
  Assumes the pads change asynchronously to clk_i.
*/
`timescale 1ns/100ps

module pag_sync (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic [7:0] in_i,
  output logic      [7:0] q_o
);

  pag_pkg::pag_sync_t st;
  pag_pkg::pag_sync_t next_st;
  logic [7:0]         differ;

  always_comb
  begin
    next_st    = st;
    differ     = st.s2 ^ st.s3;
    next_st.s1 = in_i;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    // a change counts once stages two and three agree
    next_st.q  = (~differ & st.s3) | (differ & st.q);
    if (rst_i)
    begin
      next_st = '0;
    end
  end

  always_ff @(posedge clk_i)
  begin
    st <= next_st;
  end

  assign q_o = st.q;

endmodule : pag_sync

// ### hdl/pag_pin_mux.sv
/*
  Per-pin steering of direction, latch, LED drive and analog routing.
  Assumes all inputs come from logic on the same clock.
*/
`timescale 1ns/100ps

`include "pag_cfg.svh"

module pag_pin_mux (
  input  wire logic [7:0]       dir_i,
  input  wire logic [7:0]       latch_i,
  input  wire logic [7:0]       led_i,
  input  wire logic [4:0]       chan_i,
  output pag_pkg::pag_pad_t     pad_o
);

  genvar i;

  generate
    for (i = 0; i < `PAG_NUM_PINS; i = i + 1)
    begin : g_pin
      logic routed;
      logic drive;
      assign routed = (chan_i == 5'(i));
      assign drive  = dir_i[i] & ~routed;
      assign pad_o.out[i]    = drive & latch_i[i];
      assign pad_o.oe_n[i]   = ~drive;
      assign pad_o.led[i]    = drive & led_i[i];
      assign pad_o.analog[i] = routed;
    end
  endgenerate

endmodule : pag_pin_mux

// ### hdl/pag_port.sv
/*
  Port A general-purpose I/O block: output latch, direction and LED
  drive registers on classic Wishbone, eight pads shared with the
  analog converter. Assumes one 125 MHz clock, synchronous reset, and
  an analog channel select coming from logic on the same clock.
*/
`timescale 1ns/100ps

`include "pag_cfg.svh"

////////////////////////////////////////////////////////////////////////

// Operation
// - eight latches at 0x00, kept over reset
// - direction 1 drives latch, 0 floats
// - reset clears direction; direction is read/write
// - output pin reads back its latch
// - input pin reads back pin level
// - writes with wb_sel_i[0] set update every latch bit
// - selected analog channel takes pin away
// - unselected pins stay ordinary digital I/O
// - each pin may enable LED drive
// - LED bits read/write, active on outputs
module pag_port (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic [4:0]  analog_channel_select_i,
  input  wire logic [7:0]  pin_i,
  output logic      [7:0]  pin_o,
  output logic      [7:0]  pin_oe_n_o,
  output logic      [7:0]  led_drive_enable_o,
  output logic      [7:0]  analog_route_o
);

  ////////////////////////////////////////////////////////////////////////
  // state and helpers

  pag_pkg::pag_state_t st;
  pag_pkg::pag_state_t next_st;
  pag_pkg::pag_pad_t   pad;
  logic [7:0]          pin_sync;
  logic                take;
  logic                wr_lane;
  logic [7:0]          rd_byte;

  ////////////////////////////////////////////////////////////////////////
  // pad input synchroniser and pin steering

  pag_sync u_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .in_i  (pin_i),
    .q_o   (pin_sync)
  );

  pag_pin_mux u_mux (
    .dir_i   (st.dir),
    .latch_i (st.latch),
    .led_i   (st.led),
    .chan_i  (analog_channel_select_i),
    .pad_o   (pad)
  );

  ////////////////////////////////////////////////////////////////////////
  // bus slave and registers

  assign take    = wb_cyc_i & wb_stb_i & ~st.ack;
  assign wr_lane = take & wb_we_i & wb_sel_i[0];

  always_comb
  begin
    next_st = st;
    rd_byte = 8'h00;
    case (wb_adr_i)
      `PAG_ADR_LATCH: rd_byte = (st.dir & st.latch) | (~st.dir & pin_sync);
      `PAG_ADR_DIR:   rd_byte = st.dir;
      `PAG_ADR_LED:   rd_byte = st.led;
      `PAG_ADR_ROUTE: rd_byte = st.pad.analog;
      default:        rd_byte = 8'h00;
    endcase
    next_st.ack = take;
    if (take)
    begin
      next_st.rdat = {24'h000000, rd_byte};
    end
    if (wr_lane)
    begin
      case (wb_adr_i)
        `PAG_ADR_LATCH: next_st.latch = wb_dat_i[7:0];
        `PAG_ADR_DIR:   next_st.dir   = wb_dat_i[7:0];
        `PAG_ADR_LED:   next_st.led   = wb_dat_i[7:0];
        default:        next_st.led   = st.led;
      endcase
    end
    next_st.pad = pad;
    if (rst_i)
    begin
      next_st.dir         = `PAG_DIR_RST;
      next_st.led         = `PAG_LED_RST;
      next_st.ack         = 1'b0;
      next_st.rdat        = 32'h00000000;
      next_st.pad.out     = 8'h00;
      next_st.pad.oe_n    = 8'hff;
      next_st.pad.led     = 8'h00;
      next_st.pad.analog  = 8'h00;
    end
  end

  always_ff @(posedge clk_i)
  begin
    st <= next_st;
  end

  assign wb_dat_o           = st.rdat;
  assign wb_ack_o           = st.ack;
  assign pin_o              = st.pad.out;
  assign pin_oe_n_o         = st.pad.oe_n;
  assign led_drive_enable_o = st.pad.led;
  assign analog_route_o     = st.pad.analog;

  ////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk_i);
  endclocking

  default disable iff (rst_i);

  logic       past_valid;
  logic       latch_seen;
  logic [2:0] settle_cnt;
  genvar      p;

  always_ff @(posedge clk_i)
  begin
    past_valid <= ~rst_i;
  end

  // set by the first latch write, never reset
  always_ff @(posedge clk_i)
  begin
    latch_seen <= latch_seen | (wr_lane && wb_adr_i == `PAG_ADR_LATCH);
  end

  // edges since reset, saturating at four
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      settle_cnt <= 3'h0;
    end
    else if (settle_cnt != 3'h4)
    begin
      settle_cnt <= settle_cnt + 3'h1;
    end
  end

  chk_latch_kept: assert property (
    @(posedge clk_i) disable iff (1'b0)
    rst_i && latch_seen |=> st.latch == $past(st.latch))
    else $error("output latch changed by reset");

  chk_dir_reset: assert property (
    @(posedge clk_i) disable iff (1'b0)
    rst_i |=> (st.dir == 8'h00) ##1 (pin_oe_n_o == 8'hff))
    else $error("direction not cleared by reset");

  chk_latch_write: assert property (
    (take && wb_we_i && wb_sel_i[0] && wb_adr_i == `PAG_ADR_LATCH)
    |=> st.latch == $past(wb_dat_i[7:0]))
    else $error("latch write lost");

  chk_read_latch: assert property (
    (take && !wb_we_i && wb_adr_i == `PAG_ADR_LATCH && st.dir == 8'hff)
    |=> wb_ack_o && wb_dat_o[7:0] == $past(st.latch))
    else $error("output pin did not read latch");

  chk_read_pin: assert property (
    (take && !wb_we_i && wb_adr_i == `PAG_ADR_LATCH && st.dir == 8'h00)
    |=> wb_ack_o && wb_dat_o[7:0] == $past(pin_sync))
    else $error("input pin did not read pin level");

  // driven pins carry latch, others float
  chk_drive_latch: assert property (
    past_valid |=> (pin_oe_n_o == ~($past(st.dir) & ~$past(pad.analog)))
    && (pin_o == ($past(st.latch) & ~$past(pad.oe_n))))
    else $error("pad drive does not follow direction");

  chk_analog_off: assert property (
    past_valid && analog_channel_select_i == 5'h03
    |=> analog_route_o == 8'h08 && pin_oe_n_o[3] && !led_drive_enable_o[3])
    else $error("analog pin still under port control");

  // out-of-range channel leaves all pins digital
  chk_digital_pin: assert property (
    past_valid && analog_channel_select_i[4:3] != 2'b00
    |=> analog_route_o == 8'h00 && pin_oe_n_o == ~$past(st.dir))
    else $error("unselected pin not digital");

  chk_led_mode: assert property (
    past_valid |=> led_drive_enable_o == ($past(st.led) & ~$past(pad.oe_n)))
    else $error("led drive outside output mode");

  chk_ack_pulse: assert property (
    take |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack not a single pulse");

  chk_ack_cause: assert property (
    wb_ack_o |-> $past(take))
    else $error("ack without a request");

  chk_rdat_hold: assert property (
    !take |=> $stable(wb_dat_o))
    else $error("read data changed without a request");

  chk_unmapped_read: assert property (
    (take && !wb_we_i && wb_adr_i[7:4] != 4'h0)
    |=> wb_ack_o && wb_dat_o == 32'h00000000)
    else $error("unmapped read not zero");

  chk_dir_write: assert property (
    (wr_lane && wb_adr_i == `PAG_ADR_DIR)
    |=> st.dir == $past(wb_dat_i[7:0]))
    else $error("direction write lost");

  chk_dir_hold: assert property (
    !(wr_lane && wb_adr_i == `PAG_ADR_DIR) |=> $stable(st.dir))
    else $error("direction changed without a write");

  chk_led_write: assert property (
    (wr_lane && wb_adr_i == `PAG_ADR_LED)
    |=> st.led == $past(wb_dat_i[7:0]))
    else $error("led enable write lost");

  chk_sync_settle: assert property (
    settle_cnt == 3'h4 && $past(pin_i, 3) == $past(pin_i, 4)
    |-> pin_sync == $past(pin_i, 4))
    else $error("steady pad level not synchronised");

  generate
    for (p = 0; p < `PAG_NUM_PINS; p = p + 1)
    begin : g_chk
      chk_pin_read: assert property (
        (take && !wb_we_i && wb_adr_i == `PAG_ADR_LATCH)
        |=> wb_dat_o[p] == ($past(st.dir[p]) ? $past(st.latch[p])
                                              : $past(pin_sync[p])))
        else $error("pin readback wrong");

      chk_pin_routed: assert property (
        past_valid && analog_channel_select_i == 5'(p)
        |=> analog_route_o[p] && pin_oe_n_o[p] && !pin_o[p]
            && !led_drive_enable_o[p])
        else $error("routed pin still driven");

      chk_pin_digital: assert property (
        past_valid && analog_channel_select_i != 5'(p)
        |=> !analog_route_o[p] && pin_oe_n_o[p] == !$past(st.dir[p]))
        else $error("unrouted pin ignores direction");
    end
  endgenerate

  cov_read_input: cover property (
    take && !wb_we_i && wb_adr_i == `PAG_ADR_LATCH && st.dir == 8'h00);

  cov_write_dir: cover property (
    take && wb_we_i && wb_adr_i == `PAG_ADR_DIR);

  cov_led_on: cover property (led_drive_enable_o != 8'h00);

  cov_analog_out: cover property (
    (analog_route_o & ~st.dir) == 8'h00 && analog_route_o != 8'h00);

endmodule : pag_port

// ### dv/pag_pad_model.sv
/*
  Pad model for port A: a driven pad shows the block's output value,
  an undriven one the level the outside world puts on it.
  Assumes the bench changes the outside level between checks.
*/
`timescale 1ns/100ps

module pag_pad_model (
  input  wire logic [7:0] out_i,
  input  wire logic [7:0] oe_n_i,
  input  wire logic [7:0] ext_i,
  output logic      [7:0] pin_o
);
  assign pin_o = (out_i & ~oe_n_i) | (ext_i & oe_n_i);
endmodule : pag_pad_model

// ### dv/pag_port_tb.sv
/*
  Self-checking bench of pag_port against a behavioural model.
  Assumes classic Wishbone timing and a 4-flop pad synchroniser.
*/
`timescale 1ns/100ps

module pag_port_tb;
  logic        clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic        ack;
  logic [7:0]  adr = 8'h00, m_dir, m_lat, m_led, ext = 8'h00, rte, pin;
  logic [7:0]  po, oen, led, ar;
  logic [31:0] wd = 32'h00000000, rd, dato;
  logic [4:0]  ch = 5'h1f;
  int          mismatches = 0, checks = 0, i;

  always #4 clk_i = ~clk_i;

  pag_port dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
    .wb_dat_i(wd), .wb_dat_o(dato), .wb_ack_o(ack),
    .analog_channel_select_i(ch), .pin_i(pin), .pin_o(po),
    .pin_oe_n_o(oen), .led_drive_enable_o(led), .analog_route_o(ar));
  pag_pad_model pads_u (.out_i(po), .oe_n_i(oen), .ext_i(ext),
    .pin_o(pin));

  ////////////////////////////////////////////////////////////////////
  task conclude;
    $display("mismatches=%0d checks=%0d", mismatches, checks);
    if (mismatches == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : conclude

  task cmp_rd(input logic [31:0] got, input logic [7:0] exp);
    checks++;
    if (got !== {24'h0, exp})
    begin
      mismatches++;
      $display("BAD %0t read %h exp %h", $time, got, exp);
    end
  endtask : cmp_rd

  task cmp_pad(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("BAD %0t pads %h exp %h", $time, got, exp);
    end
  endtask : cmp_pad

  task wb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wd <= {24'h000000, d};
    for (n = 0; n < 20 && ack !== 1'b1; n++) @(posedge clk_i);
    rd = dato;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    if (n == 20)
    begin
      mismatches++;
      $display("BAD %0t no ack", $time);
      conclude();
    end
  endtask : wb

  task chk_all;
    repeat (6) @(posedge clk_i);
    rte = (ch < 8) ? 8'h01 << ch[2:0] : 8'h00;
    cmp_pad(oen, ~(m_dir & ~rte));
    cmp_pad(po, m_lat & m_dir & ~rte);
    cmp_pad(led, m_led & m_dir & ~rte);
    cmp_pad(ar, rte);
    wb(1'b0, 8'h00, 8'h00);
    cmp_rd(rd, (m_dir & m_lat) | (~m_dir & ext));
    wb(1'b0, 8'h04, 8'h00);
    cmp_rd(rd, m_dir);
    wb(1'b0, 8'h08, 8'h00);
    cmp_rd(rd, m_led);
    wb(1'b0, 8'h0c, 8'h00);
    cmp_rd(rd, rte);
  endtask : chk_all

  ////////////////////////////////////////////////////////////////////
  initial
  begin
    void'($urandom(32'h16582ab1));
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    m_dir = 8'h00;
    m_led = 8'h00;
    m_lat = 8'h5a;
    wb(1'b1, 8'h00, m_lat);
    chk_all();
    for (i = 0; i < 14; i++)
    begin
      // latch first, then direction
      m_lat = 8'($urandom);
      wb(1'b1, 8'h00, m_lat);
      m_dir = 8'($urandom);
      wb(1'b1, 8'h04, m_dir);
      m_led = 8'($urandom);
      wb(1'b1, 8'h08, m_led);
      ext <= 8'($urandom);
      ch <= (i < 9) ? i[4:0] : 5'($urandom);
      chk_all();
    end
    wb(1'b1, 8'h0c, 8'hff);
    wb(1'b1, 8'h10, 8'hff);
    wb(1'b0, 8'h10, 8'h00);
    cmp_rd(rd, 8'h00);
    chk_all();
    // reset mid-run keeps the latch
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    m_dir = 8'h00;
    m_led = 8'h00;
    chk_all();
    m_dir = 8'hff;
    wb(1'b1, 8'h04, m_dir);
    chk_all();
    conclude();
  end
endmodule : pag_port_tb
